// file: rtl/move_pkg.sv
// constants, register map and types of the move trajectory generator
// assumes a single core clock domain shared by every module using it
package move_pkg;

    // register byte offsets, one aligned word each
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SPEED = 8'h04;
    localparam logic [7:0] OFF_MAX_SPEED = 8'h08;
    localparam logic [7:0] OFF_ACCEL = 8'h0C;
    localparam logic [7:0] OFF_DECEL = 8'h10;
    localparam logic [7:0] OFF_DEST_STEPS = 8'h14;
    localparam logic [7:0] OFF_DEST_USTEP = 8'h18;
    localparam logic [7:0] OFF_DISP = 8'h1C;
    localparam logic [7:0] OFF_CMD = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_POS = 8'h28;
    localparam logic [7:0] OFF_CUR_SPEED = 8'h2C;
    localparam logic [7:0] OFF_DEST = 8'h30;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h34;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h38;

    // control field positions and reset value
    localparam int CTRL_ACCEL_EN = 0;
    localparam int CTRL_DECEL_EN = 1;
    localparam int CTRL_MAX_EN = 2;
    localparam int CTRL_ENC_UNITS = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'h3;

    // command word bits, write only
    localparam int CMD_ABS = 0;
    localparam int CMD_REL = 1;
    localparam int CMD_STOP = 2;

    // status word bits
    localparam int STAT_MOVING = 0;
    localparam int STAT_DIR = 1;
    localparam int STAT_ACCEL = 2;
    localparam int STAT_CRUISE = 3;
    localparam int STAT_DECEL = 4;
    localparam int STAT_STOPPING = 5;

    // interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_W = 2;

    // speed in position units per second
    localparam int SPEED_W = 17;
    localparam int unsigned SPEED_CEIL = 100000;
    localparam logic [16:0] SPEED_RESET = 17'h003E8;
    localparam logic [31:0] ACCEL_RESET = 32'h00002710;
    localparam logic [31:0] DECEL_RESET = 32'h00002710;

    // timing
    localparam int unsigned CLK_HZ_DEF = 20000000;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned RAMP_LIMIT_MIN = 5;
    localparam int unsigned RAMP_LIMIT_S = RAMP_LIMIT_MIN * 60;
    // slowest ramp that still reaches top speed in under the limit
    localparam logic [31:0] RATE_MIN =
        32'((SPEED_CEIL + RAMP_LIMIT_S - 1) / RAMP_LIMIT_S);
    // at most one speed unit per clock
    localparam logic [31:0] RATE_MAX = 32'(CLK_HZ_DEF - 1);

    // positioning
    localparam int POS_W = 32;
    localparam int USTEP_W = 8;
    localparam int USTEP_PER_STEP_DEF = 256;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ACCEL = 4'b0010,
        ST_CRUISE = 4'b0100,
        ST_DECEL = 4'b1000
    } motion_state_type;

endpackage

// file: rtl/ramp_if.sv
// carrier between the register file and one ramp rate checker
// assumes both ends run on the same core clock
`timescale 1ns/100ps
interface ramp_if;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] value;
    logic err;
    modport cfg (output wr, output wdata, input value, input err);
    modport chk (input wr, input wdata, output value, output err);
endinterface

// file: rtl/ramp_check.sv
// holds one ramp rate, range checked and clamped on every write
// assumes writes come from the register file on the core clock
`timescale 1ns/100ps
module ramp_check
    import move_pkg::*;
#(
    parameter logic [31:0] RESET_VAL = ACCEL_RESET
) (
    input wire logic core_clk,
    input wire logic reset,
    ramp_if.chk bus
);

    logic [31:0] value_q;
    logic err_q;

    // too slow or too fast values flag an error and are replaced
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            value_q <= RESET_VAL;
            err_q <= 1'b0;
        end else begin
            err_q <= 1'b0;
            if (bus.wr) begin
                if (bus.wdata < RATE_MIN) begin
                    value_q <= RATE_MIN;
                    err_q <= 1'b1;
                end else if (bus.wdata > RATE_MAX) begin
                    value_q <= RATE_MAX;
                    err_q <= 1'b1;
                end else begin
                    value_q <= bus.wdata;
                end
            end
        end
    end

    assign bus.value = value_q;
    assign bus.err = err_q;

endmodule

// file: rtl/move_trajectory_generator.sv
// one axis move trajectory generator: absolute and relative moves
// with trapezoidal or triangular speed profile, step and direction out
// assumes a plain register port on core_clk, an asynchronous sync pin,
// and an encoder position produced by logic on the same clock
//
// Notes on behaviour
// - absolute move drives axis to given coordinate
// - start ramps up, or runs at speed at once
// - halt at destination, decelerating only if enabled
// - destination in steps plus microsteps or counts
// - first relative move counts from zero
// - idle relative move: current position plus displacement
// - relative move in flight adds to destination
// - during rotation, add to previous destination
// - base is last targeted point, done or not; a smooth stop instead makes the stop point the base
// - relative move from command or sync pulse
// - accel on by default, separate accel, decel
// - raise speed at accel rate to target
// - start braking so rest falls on destination
// - short move goes accel straight to decel
// - ramp needing five minutes is error, clamped
// - commanded speed clamped to configured maximum
// - speed never above 100000 per second
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module move_trajectory_generator
    import move_pkg::*;
#(
    parameter int USTEPS = USTEP_PER_STEP_DEF,
    parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic sync_pulse,
    input wire logic [31:0] enc_pos,
    output logic step_out,
    output logic dir_out,
    output logic moving_out,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // register file

    logic [CTRL_W-1:0] ctrl_q;
    logic [SPEED_W-1:0] speed_q;
    logic [SPEED_W-1:0] max_speed_q;
    logic [31:0] dest_steps_q;
    logic [USTEP_W-1:0] dest_ustep_q;
    logic [31:0] disp_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [31:0] rdata_q;
    logic irq_q;

    ramp_if accel_bus ();
    ramp_if decel_bus ();

    // separate accel and decel rates, each checked on write
    assign accel_bus.wr = reg_wr && (reg_addr == OFF_ACCEL);
    assign accel_bus.wdata = reg_wdata;
    assign decel_bus.wr = reg_wr && (reg_addr == OFF_DECEL);
    assign decel_bus.wdata = reg_wdata;

    ramp_check #(.RESET_VAL(ACCEL_RESET)) accel_chk (
        .core_clk(core_clk),
        .reset(reset),
        .bus(accel_bus)
    );

    ramp_check #(.RESET_VAL(DECEL_RESET)) decel_chk (
        .core_clk(core_clk),
        .reset(reset),
        .bus(decel_bus)
    );

    // configuration writes; acceleration enabled out of reset
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
            speed_q <= SPEED_RESET;
            max_speed_q <= SPEED_W'(SPEED_CEIL);
            dest_steps_q <= '0;
            dest_ustep_q <= '0;
            disp_q <= '0;
            irq_mask_q <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                OFF_CTRL: ctrl_q <= reg_wdata[CTRL_W-1:0];
                OFF_SPEED: speed_q <= reg_wdata[SPEED_W-1:0];
                OFF_MAX_SPEED: max_speed_q <= reg_wdata[SPEED_W-1:0];
                OFF_DEST_STEPS: dest_steps_q <= reg_wdata;
                OFF_DEST_USTEP: dest_ustep_q <= reg_wdata[USTEP_W-1:0];
                OFF_DISP: disp_q <= reg_wdata;
                OFF_IRQ_MASK: irq_mask_q <= reg_wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command decode and sync pulse

    logic sync_meta_q;
    logic sync_sync_q;
    logic sync_prev_q;
    logic cmd_wr;
    logic abs_go;
    logic rel_go;
    logic stop_go;

    // two flops before anything looks at the pin
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync_meta_q <= 1'b0;
            sync_sync_q <= 1'b0;
            sync_prev_q <= 1'b0;
        end else begin
            sync_meta_q <= sync_pulse;
            sync_sync_q <= sync_meta_q;
            sync_prev_q <= sync_sync_q;
        end
    end

    assign cmd_wr = reg_wr && (reg_addr == OFF_CMD);
    assign abs_go = cmd_wr && reg_wdata[CMD_ABS];
    // rising sync edge acts exactly like a relative command
    assign rel_go = (cmd_wr && reg_wdata[CMD_REL] && !reg_wdata[CMD_ABS])
        || (sync_sync_q && !sync_prev_q);
    assign stop_go = cmd_wr && reg_wdata[CMD_STOP];

    ////////////////////////////////////////////////////////////////////
    // trajectory datapath

    motion_state_type state_q;
    logic [SPEED_W-1:0] cur_q;
    logic dir_q;
    logic stop_q;
    logic [24:0] pacc_q;
    logic [24:0] racc_q;
    logic [POS_W-1:0] pos_q;
    logic [POS_W-1:0] dest_q;
    logic [POS_W-1:0] dest_d;
    logic [POS_W-1:0] act_pos;
    logic [POS_W-1:0] abs_target;
    logic [POS_W:0] rem;
    logic [POS_W-1:0] rem_abs;
    logic [SPEED_W-1:0] limit;
    logic [SPEED_W-1:0] tgt;
    logic [64:0] brake_lhs;
    logic [33:0] stop_rhs;
    logic need_decel;
    logic wrong_dir;
    logic arrived;
    logic stop_done;
    logic idle;
    logic [31:0] rate;
    logic [25:0] pacc_sum;
    logic [25:0] racc_sum;
    logic step_tick;
    logic ramp_tick;
    logic done_evt;

    assign idle = (state_q == ST_IDLE);
    // position feedback and destination share one unit
    assign act_pos = ctrl_q[CTRL_ENC_UNITS] ? enc_pos : pos_q;
    // steps scaled to microsteps, or raw encoder counts
    assign abs_target = ctrl_q[CTRL_ENC_UNITS] ? dest_steps_q
        : POS_W'(dest_steps_q * USTEPS) + POS_W'(dest_ustep_q);

    // a smooth stop ends once the motor is down to its slowest speed
    assign stop_done = !idle && stop_q && (cur_q <= SPEED_W'(1));

    // destination update; base is the current position when idle, else the last targeted point
    always_comb begin
        dest_d = dest_q;
        if (abs_go) begin
            dest_d = abs_target;
        end else if (rel_go) begin
            if (idle) begin
                // reset value of the position makes the first base zero
                dest_d = act_pos + disp_q;
            end else begin
                // add on the fly, no halt, also while stopping
                dest_d = dest_q + disp_q;
            end
        end else if (stop_done) begin
            dest_d = act_pos;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dest_q <= '0;
        end else begin
            dest_q <= dest_d;
        end
    end

    // distance left, sign gives the direction needed
    assign rem = {dest_d[POS_W-1], dest_d} - {act_pos[POS_W-1], act_pos};
    assign rem_abs = rem[POS_W] ? POS_W'(-rem) : rem[POS_W-1:0];
    assign arrived = (rem == '0);
    assign wrong_dir = !arrived && (rem[POS_W] != dir_q);

    // configured speed clamped by user maximum and hard ceiling
    assign limit = ctrl_q[CTRL_MAX_EN] ? max_speed_q
        : SPEED_W'(SPEED_CEIL);
    always_comb begin
        tgt = (speed_q > limit) ? limit : speed_q;
        if (tgt > SPEED_W'(SPEED_CEIL)) begin
            tgt = SPEED_W'(SPEED_CEIL);
        end
    end

    // braking distance v^2/(2d) reached: start slowing now
    assign brake_lhs = 65'({rem_abs, 1'b0}) * 65'(decel_bus.value);
    assign stop_rhs = 34'(cur_q) * 34'(cur_q);
    assign need_decel = ctrl_q[CTRL_DECEL_EN]
        && (brake_lhs <= 65'(stop_rhs));

    // step phase accumulator; speed below the clock rate by design
    assign pacc_sum = 26'(pacc_q) + 26'(cur_q);
    assign step_tick = !idle && (pacc_sum >= 26'(CLK_HZ));
    assign rate = (state_q == ST_DECEL) ? decel_bus.value
        : accel_bus.value;
    assign racc_sum = 26'(racc_q) + 26'(rate);
    assign ramp_tick = (racc_sum >= 26'(CLK_HZ));

    ////////////////////////////////////////////////////////////////////
    // motion state machine

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cur_q <= '0;
            dir_q <= 1'b0;
            stop_q <= 1'b0;
            racc_q <= '0;
            done_evt <= 1'b0;
        end else begin
            done_evt <= 1'b0;
            racc_q <= ramp_tick ? 25'(racc_sum - 26'(CLK_HZ))
                : racc_sum[24:0];
            if (abs_go || rel_go) begin
                stop_q <= 1'b0;
            end else if (stop_go && !idle) begin
                stop_q <= 1'b1;
            end
            unique case (state_q)
                ST_IDLE: begin
                    racc_q <= '0;
                    if ((abs_go || rel_go) && !arrived) begin
                        dir_q <= rem[POS_W];
                        state_q <= ST_ACCEL;
                        // no ramp: full speed from the first cycle
                        cur_q <= ctrl_q[CTRL_ACCEL_EN] ? SPEED_W'(1)
                            : tgt;
                    end
                end
                default: begin
                    if (stop_done || (arrived && !stop_q)) begin
                        // at rest on the destination
                        state_q <= ST_IDLE;
                        cur_q <= '0;
                        stop_q <= 1'b0;
                        done_evt <= 1'b1;
                    end else if (wrong_dir && cur_q <= SPEED_W'(1)) begin
                        // reversal only from the slowest speed
                        dir_q <= rem[POS_W];
                        state_q <= ST_ACCEL;
                    end else if (stop_q || wrong_dir || need_decel) begin
                        // entered from accel too: triangular profile
                        state_q <= ST_DECEL;
                        if (!ctrl_q[CTRL_DECEL_EN] && !wrong_dir) begin
                            cur_q <= SPEED_W'(1);
                        end else if (ramp_tick && cur_q > SPEED_W'(1))
                        begin
                            cur_q <= cur_q - SPEED_W'(1);
                        end
                    end else if (!ctrl_q[CTRL_ACCEL_EN]) begin
                        state_q <= ST_CRUISE;
                        cur_q <= tgt;
                    end else if (cur_q < tgt) begin
                        state_q <= ST_ACCEL;
                        if (ramp_tick) begin
                            cur_q <= cur_q + SPEED_W'(1);
                        end
                    end else begin
                        // target reached or lowered: hold it
                        state_q <= ST_CRUISE;
                        cur_q <= tgt;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // step generation and commanded position

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pacc_q <= '0;
            pos_q <= '0;
            step_out <= 1'b0;
            dir_out <= 1'b0;
        end else begin
            step_out <= 1'b0;
            dir_out <= dir_q;
            if (idle) begin
                pacc_q <= '0;
            end else if (step_tick && !arrived && !wrong_dir) begin
                // never step past the target; waits for reversal
                pacc_q <= 25'(pacc_sum - 26'(CLK_HZ));
                step_out <= 1'b1;
                pos_q <= dir_q ? pos_q - POS_W'(1) : pos_q + POS_W'(1);
            end else if (!step_tick) begin
                pacc_q <= pacc_sum[24:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupts, status and read port

    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    assign irq_set[IRQ_DONE] = done_evt;
    assign irq_set[IRQ_ERR] = accel_bus.err || decel_bus.err;
    assign irq_clr = (reg_wr && reg_addr == OFF_IRQ_STAT)
        ? reg_wdata[IRQ_W-1:0] : '0;

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq_stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            irq_q <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
        end
    end
    assign irq = irq_q;

    // moving flag follows the state machine, one cycle behind
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            moving_out <= 1'b0;
        end else begin
            moving_out <= !idle;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= '0;
            if (reg_rd) begin
                unique case (reg_addr)
                    OFF_CTRL: rdata_q <= 32'(ctrl_q);
                    OFF_SPEED: rdata_q <= 32'(speed_q);
                    OFF_MAX_SPEED: rdata_q <= 32'(max_speed_q);
                    OFF_ACCEL: rdata_q <= accel_bus.value;
                    OFF_DECEL: rdata_q <= decel_bus.value;
                    OFF_DEST_STEPS: rdata_q <= dest_steps_q;
                    OFF_DEST_USTEP: rdata_q <= 32'(dest_ustep_q);
                    OFF_DISP: rdata_q <= disp_q;
                    OFF_STATUS: begin
                        rdata_q[STAT_MOVING] <= !idle;
                        rdata_q[STAT_DIR] <= dir_q;
                        rdata_q[STAT_ACCEL] <= (state_q == ST_ACCEL);
                        rdata_q[STAT_CRUISE] <= (state_q == ST_CRUISE);
                        rdata_q[STAT_DECEL] <= (state_q == ST_DECEL);
                        rdata_q[STAT_STOPPING] <= stop_q;
                    end
                    OFF_POS: rdata_q <= act_pos;
                    OFF_CUR_SPEED: rdata_q <= 32'(cur_q);
                    OFF_DEST: rdata_q <= dest_q;
                    OFF_IRQ_STAT: rdata_q <= 32'(irq_stat_q);
                    OFF_IRQ_MASK: rdata_q <= 32'(irq_mask_q);
                    default: rdata_q <= '0;
                endcase
            end
        end
    end
    assign reg_rdata = rdata_q;

endmodule

// file: dv/move_monitor.sv
// checker on the top ports of the move trajectory generator
// assumes one core clock and an active high asynchronous reset
`timescale 1ns/100ps
module move_monitor
    import move_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic sync_pulse,
    input wire logic step_out,
    input wire logic moving_out,
    input wire logic irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
////////////////////////////////////////////////////////////////////////
    // read data only in the cycle after a read strobe
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    unmapped_read_a: assert property (
        $past(reg_rd) && $past(reg_addr) > OFF_IRQ_MASK
        |-> reg_rdata == 32'h0) else $error("unmapped read not zero");
    ctrl_width_a: assert property (
        $past(reg_rd) && $past(reg_addr) == OFF_CTRL
        |-> reg_rdata[31:4] == 28'h0) else $error("control upper bits");
    // a too slow rate written and read back shows the clamp
    ramp_low_a: assert property (
        reg_wr && reg_addr == OFF_ACCEL && reg_wdata < RATE_MIN
        ##2 reg_rd && reg_addr == OFF_ACCEL |=> reg_rdata == RATE_MIN)
        else $error("low rate not clamped");
    ramp_high_a: assert property (
        reg_wr && reg_addr == OFF_DECEL && reg_wdata > RATE_MAX
        ##2 reg_rd && reg_addr == OFF_DECEL |=> reg_rdata == RATE_MAX)
        else $error("high rate not clamped");
    speed_cap_a: assert property (
        $past(reg_rd) && $past(reg_addr) == OFF_CUR_SPEED
        |-> reg_rdata <= SPEED_CEIL) else $error("speed above ceiling");
    // no step outside a move, allowing the arrival edge
    step_moving_a: assert property (
        step_out |-> moving_out || $past(moving_out))
        else $error("step while at rest");
    move_start_a: assert property (
        $rose(moving_out) |-> $past(reg_wr, 2) && $past(reg_addr, 2) ==
        OFF_CMD || $past(sync_pulse, 2)) else $error("move without a start");
    // reset gates every output low
    reset_quiet_a: assert property (disable iff (1'b0)
        reset |-> !step_out && !moving_out && !irq && reg_rdata == 32'h0)
        else $error("output active in reset");
endmodule

// file: dv/motor_model.sv
// motor with encoder on the far side of step and direction
// assumes steps arrive as one-cycle pulses on the core clock
`timescale 1ns/100ps
module motor_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic step_out,
    input wire logic dir_out,
    input wire logic fire,
    output logic [31:0] enc_pos,
    output logic sync_pulse
);
    logic [2:0] width_q;
////////////////////////////////////////////////////////////////////////
    // shaft follows every step, the encoder reads it back unchanged
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            enc_pos <= 32'h0;
        end else if (step_out) begin
            enc_pos <= dir_out ? enc_pos - 32'h1 : enc_pos + 32'h1;
        end
    end
    // pulse held six cycles so the pin synchroniser cannot miss it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            width_q <= 3'h0;
        end else if (fire) begin
            width_q <= 3'h6;
        end else if (width_q != 3'h0) begin
            width_q <= width_q - 3'h1;
        end
    end
    assign sync_pulse = width_q != 3'h0;
endmodule

// file: dv/move_trajectory_generator_bench.sv
// register driven bench for the move trajectory generator
// assumes the motor model closes the loop through the encoder
`timescale 1ns/100ps
module move_trajectory_generator_bench
    import move_pkg::*;
();
    logic core_clk = 1'b0;
    logic reset = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, fire = 1'b0;
    logic [31:0] reg_rdata, enc_pos, v, s;
    logic sync_pulse, step_out, dir_out, moving_out, irq;
    int bad_count = 0, checks_done = 0, cycles = 0;
////////////////////////////////////////////////////////////////////////
    // slow clock rate keeps the speed one crawl short
    move_trajectory_generator #(.CLK_HZ(10000)) dut (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sync_pulse(sync_pulse),
        .enc_pos(enc_pos), .step_out(step_out), .dir_out(dir_out),
        .moving_out(moving_out), .irq(irq));
    motor_model motor (.core_clk(core_clk), .reset(reset),
        .step_out(step_out), .dir_out(dir_out), .fire(fire),
        .enc_pos(enc_pos), .sync_pulse(sync_pulse));
    initial forever #25 core_clk = ~core_clk;
////////////////////////////////////////////////////////////////////////
    // idle cycle after a write keeps the strobe single driven
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk) d = reg_rdata;
        @(posedge core_clk);
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a, logic [31:0] e);
        rd(a, v);
        chk(n, e, v);
    endtask
    // polls status until rest, gathering every phase seen
    task automatic settle();
        s = 32'h0;
        do begin
            rd(OFF_STATUS, v);
            s = s | v;
        end while (v[STAT_MOVING] !== 1'b0);
    endtask
    task automatic go(input logic [31:0] st, input logic [31:0] us);
        wr(OFF_DEST_STEPS, st);
        wr(OFF_DEST_USTEP, us);
        wr(OFF_CMD, 32'h1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard, well above the longest crawl in the run
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 80000) begin
            bad_count++;
            tally_and_finish();
        end
    end
////////////////////////////////////////////////////////////////////////
    initial begin
        reset <= 1'b1;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rchk("ctrl", OFF_CTRL, 32'h3);
        rchk("speed", OFF_SPEED, 32'h3E8);
        rchk("max", OFF_MAX_SPEED, 32'h186A0);
        rchk("accel", OFF_ACCEL, 32'h2710);
        rchk("decel", OFF_DECEL, 32'h2710);
        rchk("hole", 8'h3C, 32'h0);
        // out of range rates clamp and raise the error interrupt
        wr(OFF_IRQ_MASK, 32'h3);
        wr(OFF_ACCEL, 32'h1);
        rchk("acc lo", OFF_ACCEL, 32'h14E);
        wr(OFF_DECEL, 32'hFFFFFFFF);
        rchk("dec hi", OFF_DECEL, 32'h1312CFF);
        rchk("err", OFF_IRQ_STAT, 32'h2);
        chk("irq", 32'h1, {31'h0, irq});
        wr(OFF_IRQ_STAT, 32'h2);
        rchk("clr", OFF_IRQ_STAT, 32'h0);
        wr(OFF_ACCEL, 32'h2710);
        wr(OFF_DECEL, 32'h2710);
        // constant speed, the first relative move counts from zero
        wr(OFF_CTRL, 32'h0);
        wr(OFF_DISP, 32'hA);
        wr(OFF_CMD, 32'h2);
        rchk("dest0", OFF_DEST, 32'hA);
        settle();
        rchk("pos0", OFF_POS, 32'hA);
        // relative added in flight to an absolute target
        go(32'h1, 32'h0);
        wr(OFF_DISP, 32'h4);
        wr(OFF_CMD, 32'h2);
        rchk("dest1", OFF_DEST, 32'h104);
        settle();
        chk("moved", 32'h1, {31'h0, s[STAT_MOVING]});
        rchk("pos1", OFF_POS, 32'h104);
        chk("enc1", 32'h104, enc_pos);
        rchk("done", OFF_IRQ_STAT, 32'h1);
        chk("irq1", 32'h1, {31'h0, irq});
        wr(OFF_IRQ_STAT, 32'h1);
        // outside pulse starts a backward relative move
        wr(OFF_DISP, 32'hFFFFFFFA);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (6) @(posedge core_clk);
        rchk("dest2", OFF_DEST, 32'hFE);
        settle();
        rchk("pos2", OFF_POS, 32'hFE);
        chk("enc2", 32'hFE, enc_pos);
        // speed held at the configured maximum
        wr(OFF_CTRL, 32'h4);
        wr(OFF_MAX_SPEED, 32'hC8);
        go(32'h1, 32'h18);
        rchk("max sp", OFF_CUR_SPEED, 32'hC8);
        settle();
        // trapezoid, a move too short to reach cruise, then a smooth stop
        wr(OFF_CTRL, 32'h3);
        wr(OFF_SPEED, 32'hC8);
        go(32'h1, 32'h2C);
        settle();
        chk("trap", 32'h1C, s & 32'h1C);
        rchk("pos4", OFF_POS, 32'h12C);
        wr(OFF_SPEED, 32'h3E8);
        go(32'h1, 32'h36);
        settle();
        chk("tri", 32'h14, s & 32'h1C);
        rchk("pos5", OFF_POS, 32'h136);
        go(32'h2, 32'h0);
        wr(OFF_CMD, 32'h4);
        settle();
        chk("stopping", 32'h20, s & 32'h20);
        rchk("stop dest", OFF_DEST, 32'h136);
        // encoder units as a plain count, at once at full speed
        wr(OFF_CTRL, 32'h8);
        go(32'h140, 32'h0);
        settle();
        rchk("pos6", OFF_POS, 32'h140);
        chk("enc6", 32'h140, enc_pos);
        tally_and_finish();
    end
endmodule

bind move_trajectory_generator move_monitor mon (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sync_pulse(sync_pulse),
    .step_out(step_out), .moving_out(moving_out), .irq(irq));
